// ===== rtl/osc_clock_defines.svh
// Offsets, field positions, reset values and timing counts
`ifndef OSC_CLOCK_DEFINES_SVH
`define OSC_CLOCK_DEFINES_SVH
`define OSC_CTRL_ADDR   2'h0
`define OSC_TUNE_ADDR   2'h1
`define FSEL_LSB        4
`define FSEL_MSB        5
`define LOCK_BIT        3
`define STABLE_BIT      2
`define TUNE_MSB        5
`define FSEL_RST        2'h2
`define TUNE_RST        6'h00
`define CLK_KHZ         125000
`define SRC_HI_KHZ      16000
`define SRC_LO_KHZ      500
`define ACC_W           16
`define TRIM_STEP       32
`define STARTUP_CYCLES  1024
`define LOCK_TICKS      64
`define STABLE_TICKS    256
`endif

// ===== rtl/osc_clock_pkg.sv
// Types shared by the oscillator clock select block
`include "osc_clock_defines.svh"
package osc_clock_pkg;
   // Oscillator mode strap codes
   typedef enum logic [2:0] {
      MODE_LOW_GAIN  = 3'h0,
      MODE_MED_GAIN  = 3'h1,
      MODE_HIGH_GAIN = 3'h2,
      MODE_EXT_CLOCK = 3'h3,
      MODE_INT_IO    = 3'h4,
      MODE_INT_CLKO  = 3'h5,
      MODE_RC_IO     = 3'h6,
      MODE_RC_CLKO   = 3'h7
   } osc_mode_t;
   // Start-up sequencer states
   typedef enum logic [2:0] {
      ST_RUN  = 3'b001,
      ST_POWERUP_TIMER = 3'b010,
      ST_OST  = 3'b100
   } startup_state_t;
   // Register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [1:0] addr;
      logic [7:0] wdata;
   } bus_req_t;
   // Complete block state
   typedef struct packed {
      startup_state_t st;
      logic           captured;
      osc_mode_t      mode;
      logic           pll;
      logic [1:0]     fsel;
      logic [5:0]     tune;
      logic [5:0]     trim;
      logic [15:0]    acc;
      logic [2:0]     post;
      logic           half;
      logic           clk_out;
      logic [10:0]    startup_counter;
      logic [11:0]    settle;
      logic           locked;
      logic           stable;
      logic           in_d;
      logic [7:0]     rdata;
      logic           tick;
      logic           hold;
      logic           in_gpio;
      logic           out_gpio;
      logic           out_oe;
      logic [1:0]     gain;
   } osc_state_t;
endpackage

// ===== rtl/osc_clock_select_startup.sv
// Oscillator source select, postscaler, tuning and start-up hold
`timescale 1ns/10ps
`default_nettype none
`include "osc_clock_defines.svh"
module osc_clock_select_startup
   import osc_clock_pkg::*;
#(
   parameter int LOCK_TICKS   = `LOCK_TICKS,  // Source ticks until lock
   parameter int STABLE_TICKS = `STABLE_TICKS // Source ticks until stable
) (
   input  wire logic       sys_clk,        // 125 MHz clock
   input  wire logic       resetn,         // Async reset, low
   input  wire bus_req_t   bus_req,        // Register request
   output var  logic [7:0] rdata,          // Read data, cycle after read
   input  wire logic [2:0] osc_mode_cfg,   // Mode strap
   input  wire logic       pll_enable,     // PLL enable strap
   input  wire logic       powerup_timer_enable,    // Power-up timer in use
   input  wire logic       powerup_timer_done,      // Power-up timer expired
   input  wire logic       wake_req,       // Wake-up from sleep
   input  wire logic       osc_in_pin,     // Oscillator input pin level
   output var  logic       osc_out_pin,    // Output pin drive value
   output var  logic       osc_out_oe,     // Output pin drive enable
   output var  logic       osc_in_gpio,    // Input pin free for GPIO
   output var  logic       osc_out_gpio,   // Output pin free for GPIO
   output var  logic [1:0] amp_gain,       // Amplifier gain, 0 = off
   output var  logic       sys_tick,       // System clock enable pulse
   output var  logic       core_hold       // Core held in start-up
);

   osc_state_t q;
   osc_state_t next_q;

   // Divider mask: tick passes when masked postscaler bits are zero
   function automatic logic [2:0] div_mask(input logic [1:0] sel);
      logic [2:0] m;
      m = 3'h0;
      unique case (sel)
         2'h3: m = 3'h0;
         2'h2: m = 3'h1;
         2'h1: m = 3'h3;
         2'h0: m = 3'h7;
      endcase
      return m;
   endfunction

   // Phase step for a source rate, trimmed by the signed tuning code
   function automatic logic [16:0] phase_step(input logic pll,
                                              input logic [5:0] trim);
      int base;
      int full;
      int step;
      full = (`SRC_HI_KHZ * 65536) / `CLK_KHZ;
      base = pll ? full : (`SRC_LO_KHZ * 65536) / `CLK_KHZ;
      // Trim scales with the source so the slow set never steps backwards
      step = base + ($signed(trim) * `TRIM_STEP * base) / full;
      return step[16:0];
   endfunction

   function automatic logic is_crystal(input osc_mode_t m);
      return m == MODE_LOW_GAIN || m == MODE_MED_GAIN ||
             m == MODE_HIGH_GAIN;
   endfunction

   function automatic logic is_internal(input osc_mode_t m);
      return m == MODE_INT_IO || m == MODE_INT_CLKO;
   endfunction

   logic        wr_ctrl;
   logic        wr_tune;
   logic [16:0] acc_sum;
   logic        src_tick;
   logic        in_edge;
   logic        int_tick;
   logic        ext_div_tick;

   // Request decode and shared event terms
   assign wr_ctrl  = bus_req.wr && bus_req.addr == `OSC_CTRL_ADDR;
   assign wr_tune  = bus_req.wr && bus_req.addr == `OSC_TUNE_ADDR;
   assign acc_sum  = {1'b0, q.acc} + phase_step(q.pll, q.trim);
   assign src_tick = acc_sum[16];
   assign in_edge  = osc_in_pin && !q.in_d;
   assign int_tick = src_tick &&
                     (q.post & div_mask(q.fsel)) == 3'h0;
   assign ext_div_tick = (q.mode == MODE_RC_CLKO) ? in_edge : int_tick;

   // Next-state logic for the whole block
   always_comb begin
      next_q      = q;
      next_q.in_d = osc_in_pin;
      // Capture straps once, just after reset release
      if (!q.captured) begin
         next_q.captured = 1'b1;
         next_q.mode     = osc_mode_t'(osc_mode_cfg);
         next_q.pll      = pll_enable;
      end
      // Software writes: select field and tuning only
      if (wr_ctrl) begin
         next_q.fsel = bus_req.wdata[`FSEL_MSB:`FSEL_LSB];
      end
      if (wr_tune) begin
         next_q.tune = bus_req.wdata[`TUNE_MSB:0];
      end
      // Internal source phase accumulator
      next_q.acc = acc_sum[15:0];
      if (src_tick) begin
         next_q.post = q.post + 3'h1;
         // Trim walks one code per source tick toward the target
         if ($signed(q.trim) < $signed(q.tune)) begin
            next_q.trim = q.trim + 6'h1;
         end else if ($signed(q.trim) > $signed(q.tune)) begin
            next_q.trim = q.trim - 6'h1;
         end
         // Settling counter for lock and stable status
         if (q.settle != 12'hfff) begin
            next_q.settle = q.settle + 12'h1;
         end
      end
      next_q.locked = q.settle >= 12'(LOCK_TICKS);
      next_q.stable = q.settle >= 12'(STABLE_TICKS);
      // System clock enable from the chosen source
      if (is_internal(q.mode)) begin
         next_q.tick = int_tick;
      end else begin
         next_q.tick = in_edge;
      end
      // Clock-out divide by four: toggle every second event
      if (ext_div_tick) begin
         next_q.half = !q.half;
         if (q.half) begin
            next_q.clk_out = !q.clk_out;
         end
      end
      // Pin ownership and amplifier gain per mode
      next_q.in_gpio  = is_internal(q.mode);
      next_q.out_gpio = 1'b0;
      next_q.out_oe   = 1'b0;
      next_q.gain     = 2'h0;
      unique case (q.mode)
         MODE_INT_IO:    next_q.out_gpio = 1'b1;
         MODE_INT_CLKO:  next_q.out_oe   = 1'b1;
         MODE_EXT_CLOCK: next_q.out_gpio = 1'b1;
         MODE_RC_IO:     next_q.out_gpio = 1'b1;
         MODE_RC_CLKO:   next_q.out_oe   = 1'b1;
         MODE_LOW_GAIN:  next_q.gain     = 2'h1;
         MODE_MED_GAIN:  next_q.gain     = 2'h2;
         MODE_HIGH_GAIN: next_q.gain     = 2'h3;
      endcase
      // Pin value is held low whenever the pin is not driven
      if (!next_q.out_oe) begin
         next_q.clk_out = 1'b0;
      end
      // Start-up sequencer
      unique case (q.st)
         ST_RUN: begin
            if (!q.captured) begin
               if (!is_crystal(osc_mode_t'(osc_mode_cfg))) begin
                  next_q.st = ST_RUN;
               end else if (powerup_timer_enable) begin
                  next_q.st = ST_POWERUP_TIMER;
               end else begin
                  next_q.st  = ST_OST;
                  next_q.startup_counter = 11'h0;
               end
            end else if (wake_req && is_crystal(q.mode)) begin
               next_q.st  = ST_OST;
               next_q.startup_counter = 11'h0;
            end
         end
         ST_POWERUP_TIMER: begin
            if (powerup_timer_done) begin
               next_q.st  = ST_OST;
               next_q.startup_counter = 11'h0;
            end
         end
         ST_OST: begin
            if (in_edge) begin
               next_q.startup_counter = q.startup_counter + 11'h1;
               if (q.startup_counter == 11'(`STARTUP_CYCLES - 1)) begin
                  next_q.st = ST_RUN;
               end
            end
         end
      endcase
      next_q.hold = next_q.st != ST_RUN;
      // Register read data, cycle after the strobe
      next_q.rdata = 8'h00;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            `OSC_CTRL_ADDR: begin
               next_q.rdata[`FSEL_MSB:`FSEL_LSB] = q.fsel;
               next_q.rdata[`LOCK_BIT]           = q.locked;
               next_q.rdata[`STABLE_BIT]         = q.stable;
            end
            `OSC_TUNE_ADDR: next_q.rdata[`TUNE_MSB:0] = q.tune;
            default:        next_q.rdata = 8'h00;
         endcase
      end
   end

   // State register; no clock gating, so a stopped clock only freezes it
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         q          <= '0;
         q.st       <= ST_RUN;
         q.mode     <= MODE_LOW_GAIN;
         q.fsel     <= `FSEL_RST;
         q.tune     <= `TUNE_RST;
         q.trim     <= `TUNE_RST;
         q.hold     <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // Outputs straight from the state register
   assign rdata        = q.rdata;
   assign osc_out_pin  = q.clk_out;
   assign osc_out_oe   = q.out_oe;
   assign osc_in_gpio  = q.in_gpio;
   assign osc_out_gpio = q.out_gpio;
   assign amp_gain     = q.gain;
   assign sys_tick     = q.tick;
   assign core_hold    = q.hold;

   // Checks on the block's own behaviour
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   sequence ost_done_s;
      q.st == ST_OST && in_edge && q.startup_counter == 11'h3ff;
   endsequence

   sequence wake_xtal_s;
      q.captured && q.st == ST_RUN && wake_req && is_crystal(q.mode);
   endsequence

   sequence ext_mode_s;
      q.mode == MODE_EXT_CLOCK ##1 q.mode == MODE_EXT_CLOCK;
   endsequence

   sequence clko_mode_s;
      q.mode == MODE_INT_CLKO ##1 q.mode == MODE_INT_CLKO;
   endsequence

   fsel_reset_a: assert property (
      !q.captured |-> q.fsel == 2'h2)
      else $error("select field not 10 after reset");

   fsel_now_a: assert property (
      wr_ctrl |=> q.fsel == $past(bus_req.wdata[5:4]))
      else $error("select write not applied next cycle");

   post_div_a: assert property (
      q.captured && is_internal(q.mode) && src_tick &&
      q.post == 3'h0 |=> sys_tick)
      else $error("postscaler tick missing");

   pll_fixed_a: assert property (
      q.captured && $past(q.captured) |-> $stable(q.pll))
      else $error("PLL setting changed after capture");

   trim_drift_a: assert property (
      src_tick && q.trim != q.tune |=> q.trim != $past(q.trim))
      else $error("trim did not move toward tuning value");

   tune_store_a: assert property (
      wr_tune |=> q.tune == $past(bus_req.wdata[`TUNE_MSB:0]))
      else $error("tuning value not stored");

   ost_len_a: assert property (
      $fell(q.st == ST_OST) |-> $past(q.startup_counter) == 11'h3ff && $past(in_edge))
      else $error("start-up released before 1024 edges");

   ost_release_a: assert property (
      ost_done_s |=> !core_hold)
      else $error("core still held after start-up count");

   wake_hold_a: assert property (
      wake_xtal_s |=> q.st == ST_OST ##1 core_hold)
      else $error("wake-up did not start the count");

   ext_bypass_a: assert property (
      q.captured && q.mode == MODE_EXT_CLOCK |=> !core_hold [*2])
      else $error("external clock mode held the core");

   io_mode_a: assert property (
      q.mode == MODE_INT_IO ##1 q.mode == MODE_INT_IO
      |-> osc_in_gpio && osc_out_gpio && !osc_out_oe)
      else $error("internal I/O mode pins not released");

   lock_order_a: assert property (
      q.stable |-> q.locked)
      else $error("stable without lock");

   src_gap_a: assert property (
      src_tick |=> !src_tick)
      else $error("source ticks on two cycles in a row");

   full_rate_a: assert property (
      q.captured && is_internal(q.mode) && q.fsel == 2'h3 && src_tick
      |=> sys_tick)
      else $error("select 11 dropped a source tick");

   no_src_a: assert property (
      q.captured && is_internal(q.mode) && !src_tick |=> !sys_tick)
      else $error("system tick without a source tick");

   lock_read_a: assert property (
      bus_req.rd && bus_req.addr == `OSC_CTRL_ADDR
      |=> rdata[`LOCK_BIT] == $past(q.locked))
      else $error("lock bit read wrong");

   stable_read_a: assert property (
      bus_req.rd && bus_req.addr == `OSC_CTRL_ADDR
      |=> rdata[`STABLE_BIT] == $past(q.stable))
      else $error("stable bit read wrong");

   tune_read_a: assert property (
      bus_req.rd && bus_req.addr == `OSC_TUNE_ADDR
      |=> rdata == {2'h0, $past(q.tune)})
      else $error("tuning read wrong");

   tune_reset_a: assert property (
      !q.captured |-> q.tune == 6'h00)
      else $error("tuning value not zero after reset");

   mode_fixed_a: assert property (
      q.captured && $past(q.captured) |-> $stable(q.mode))
      else $error("mode changed after capture");

   ext_pins_a: assert property (
      ext_mode_s |-> osc_out_gpio && !osc_out_oe && !osc_in_gpio)
      else $error("external clock mode pins wrong");

   clko_pins_a: assert property (
      clko_mode_s |-> osc_in_gpio && osc_out_oe && !osc_out_gpio)
      else $error("internal clock-out mode pins wrong");

   rc_io_a: assert property (
      q.mode == MODE_RC_IO ##1 q.mode == MODE_RC_IO
      |-> osc_out_gpio && !osc_out_oe)
      else $error("RC I/O mode output pin not released");

   high_gain_a: assert property (
      q.mode == MODE_HIGH_GAIN ##1 q.mode == MODE_HIGH_GAIN
      |-> amp_gain == 2'h3)
      else $error("high gain crystal mode gain wrong");

   pin_quiet_a: assert property (
      !osc_out_oe |-> !osc_out_pin)
      else $error("output pin high while not driven");

   powerup_timer_wait_a: assert property (
      q.st == ST_POWERUP_TIMER && !powerup_timer_done |=> q.st == ST_POWERUP_TIMER && core_hold)
      else $error("count began before power-up timer");

   hold_state_a: assert property (
      q.st != ST_RUN |-> core_hold)
      else $error("core running during start-up");

   ost_idle_a: assert property (
      q.st == ST_OST && !in_edge |=> q.startup_counter == $past(q.startup_counter))
      else $error("start-up count moved without an edge");

endmodule
`default_nettype wire

// ===== verif/osc_source_model.sv
// External crystal or clock source driving the oscillator input pin
`timescale 1ns/10ps
`default_nettype none
module osc_source_model #(
   parameter realtime HALF_NS = 24.0 // Half period, three system cycles
) (
   input  wire logic run,    // Source oscillating
   output var  logic osc_out // Level on the oscillator input pin
);
   // Toggle off the system edges; rest low once stopped
   initial begin
      osc_out = 1'b0;
      #1;
      forever begin
         #(HALF_NS);
         osc_out = run ? ~osc_out : 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== verif/test_osc_clock_select_startup.sv
// Self-checking bench for the oscillator clock select block
`timescale 1ns/10ps
`default_nettype none
`include "osc_clock_defines.svh"
module test_osc_clock_select_startup
   import osc_clock_pkg::*;
;
   localparam int SRC_CYC = 6; // System cycles per source period
   logic       sys_clk, resetn, pll, powerup_timer_en, powerup_timer_done, wake, run;
   bus_req_t   req;
   logic [7:0] rdata;
   logic [2:0] mode;
   logic [1:0] gain;
   logic       osc_in, osc_out, oe, in_gpio, out_gpio, tick, hold, out_d;
   int         errors, compares, ticks, outs, dt, dout, n, e;

   osc_source_model src (.run(run), .osc_out(osc_in));

   osc_clock_select_startup #(.LOCK_TICKS(4), .STABLE_TICKS(8)) dut (
      .sys_clk(sys_clk), .resetn(resetn), .bus_req(req), .rdata(rdata),
      .osc_mode_cfg(mode), .pll_enable(pll), .powerup_timer_enable(powerup_timer_en),
      .powerup_timer_done(powerup_timer_done), .wake_req(wake), .osc_in_pin(osc_in),
      .osc_out_pin(osc_out), .osc_out_oe(oe), .osc_in_gpio(in_gpio),
      .osc_out_gpio(out_gpio), .amp_gain(gain), .sys_tick(tick),
      .core_hold(hold));

   // 125 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Count system ticks and rising edges of the clock-out pin
   always @(posedge sys_clk) begin
      out_d <= osc_out;
      if (tick === 1'b1) ticks <= ticks + 1;
      if (osc_out === 1'b1 && out_d === 1'b0) outs <= outs + 1;
   end

   task automatic cyc(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask

   task automatic count(input int w);
      dt = ticks;
      dout = outs;
      cyc(w);
      dt = ticks - dt;
      dout = outs - dout;
   endtask

   task automatic chk(input string s, input logic [7:0] got, exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", s, exp, got);
      end
   endtask

   task automatic chk_rng(input string s, input int got, exp, tol);
      compares++;
      if (got < exp - tol || got > exp + tol) begin
         errors++;
         $display("unexpected %s: expected %0d, seen %0d", s, exp, got);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk);
      req <= '0;
      #1;
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] exp, msk);
      @(posedge sys_clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk);
      req <= '0;
      #1;
      chk("read data", rdata & msk, exp);
   endtask

   task automatic boot(input logic [2:0] m, input logic p, pe);
      @(posedge sys_clk);
      resetn <= 1'b0;
      mode <= m;
      pll <= p;
      powerup_timer_en <= pe;
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      cyc(2);
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Wait for the core to be let go, bounded
   task automatic wait_rel();
      n = 0;
      while (hold !== 1'b0 && n < 8000) begin
         cyc(1);
         n++;
      end
      if (n >= 8000) begin
         errors++;
         wrap_up();
      end
      chk_rng("release delay", n, `STARTUP_CYCLES * SRC_CYC, 40);
   endtask

   // Main sequence
   initial begin
      resetn = 1'b0;
      req = '0;
      mode = 3'h5;
      pll = 1'b1;
      powerup_timer_en = 1'b0;
      powerup_timer_done = 1'b0;
      wake = 1'b0;
      run = 1'b1;
      ticks = 0;
      outs = 0;
      errors = 0;
      compares = 0;
      // Reset values, field access and an unmapped index
      boot(3'h5, 1'b1, 1'b0);
      rd(`OSC_CTRL_ADDR, 8'h20, 8'hff);
      rd(`OSC_TUNE_ADDR, 8'h00, 8'hff);
      wr(2'h2, 8'hff);
      rd(2'h2, 8'h00, 8'hff);
      wr(`OSC_CTRL_ADDR, 8'hff);
      cyc(100);
      rd(`OSC_CTRL_ADDR, 8'h3c, 8'hff);
      wr(`OSC_TUNE_ADDR, 8'hff);
      rd(`OSC_TUNE_ADDR, 8'h3f, 8'hff);
      $display("test registers done");
      // Postscaler rates and clock-out in both source sets
      for (int p = 0; p < 2; p++) begin
         boot(3'h5, p[0], 1'b0);
         chk("pin use", {5'h0, oe, in_gpio, out_gpio}, 8'h06);
         if (p == 0) begin
            rd(`OSC_CTRL_ADDR, 8'h20, 8'hff);
            cyc(1300);
            rd(`OSC_CTRL_ADDR, 8'h28, 8'hff);
            cyc(1000);
            rd(`OSC_CTRL_ADDR, 8'h2c, 8'hff);
         end
         for (int f = 0; f < 4; f++) begin
            wr(`OSC_CTRL_ADDR, {2'h0, f[1:0], 4'h0});
            cyc(40);
            count(4000);
            e = 4000 * (p ? `SRC_HI_KHZ : `SRC_LO_KHZ);
            e = e / (`CLK_KHZ << (3 - f));
            n = e / 50 + 1;
            chk_rng("ticks", dt, e, n);
            chk_rng("clock-out edges", dout, e / 4, e / 200 + 1);
         end
      end
      $display("test rates done");
      // Tuning extremes move the rate down and up
      for (int t = -32; t < 32; t += 63) begin
         wr(`OSC_TUNE_ADDR, 8'(t) & 8'h3f);
         cyc(800);
         count(4000);
         e = (`SRC_HI_KHZ * 65536) / `CLK_KHZ + t * `TRIM_STEP;
         e = 4000 * e / 65536;
         chk_rng("tuned ticks", dt, e, e / 100 + 1);
      end
      $display("test tuning done");
      // Internal and external pin use, stopped clock
      boot(3'h4, 1'b1, 1'b0);
      chk("pin use", {5'h0, oe, in_gpio, out_gpio}, 8'h03);
      boot(3'h3, 1'b1, 1'b0);
      chk("ext pins", {5'h0, oe, in_gpio, out_gpio}, 8'h01);
      chk("ext hold", {7'h0, hold}, 8'h00);
      count(600);
      chk_rng("external ticks", dt, 600 / SRC_CYC, 1);
      wr(`OSC_CTRL_ADDR, 8'h10);
      run = 1'b0;
      cyc(10);
      count(200);
      chk_rng("stopped ticks", dt, 0, 0);
      rd(`OSC_CTRL_ADDR, 8'h10, 8'h30);
      run = 1'b1;
      count(600);
      chk_rng("restarted ticks", dt, 600 / SRC_CYC, 1);
      $display("test external done");
      // Crystal modes: gain, start-up count, wake and timer
      for (int m = 0; m < 3; m++) begin
         boot(m[2:0], 1'b1, 1'b0);
         chk("gain", {6'h0, gain}, {6'h0, 2'(m + 1)});
         chk("hold", {7'h0, hold}, 8'h01);
         wait_rel();
      end
      @(posedge sys_clk);
      wake <= 1'b1;
      @(posedge sys_clk);
      wake <= 1'b0;
      #1;
      chk("hold on wake", {7'h0, hold}, 8'h01);
      wait_rel();
      boot(3'h1, 1'b1, 1'b1);
      cyc(300);
      chk("hold before timer", {7'h0, hold}, 8'h01);
      @(posedge sys_clk);
      powerup_timer_done <= 1'b1;
      @(posedge sys_clk);
      powerup_timer_done <= 1'b0;
      #1;
      wait_rel();
      $display("test crystal done");
      // RC modes: clock-out in MODE_RC_CLKO is the input rate over four; MODE_RC_IO pin use
      boot(3'h7, 1'b1, 1'b0);
      count(600);
      chk_rng("rc clock-out", dout, 600 / (4 * SRC_CYC), 1);
      boot(3'h6, 1'b1, 1'b0);
      chk("rc pin use", {6'h0, oe, out_gpio}, 8'h01);
      $display("test rc done");
      wrap_up();
   end
endmodule
`default_nettype wire
